/* File: dv/muldiv_issuer.sv */
`timescale 1ns/1ps
module muldiv_issuer
    import muldiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire req_s cmd,
    input wire logic req_ready,
    output logic req_valid,
    output req_s req
);
    // ------------------------------
    // issue stage
    // ------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_valid <= 1'b0;
            req <= '0;
        end else if (req_ready) begin
            req_valid <= 1'b0;
            req <= ~req;
        end else if (go && !req_valid) begin
            req_valid <= 1'b1;
            req <= cmd;
        end
    end
endmodule

/* File: dv/muldiv_sva.sv */
`timescale 1ns/1ps
module muldiv_sva
    import muldiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire rsp_s rsp
);
    // ------------------------------
    // result checks
    // ------------------------------
    logic [63:0] prod_lo;
    logic [31:0] prod_w;
    assign prod_lo = req.a * req.b;
    assign prod_w = req.a[31:0] * req.b[31:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_ready_with_rsp: assert property (req_ready == rsp_valid)
        else $error("ready apart from result");
    a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("result valid too long");
    a_value_holds: assert property (!rsp_valid |-> $stable(rsp.value))
        else $error("result changed between answers");
    a_rsp_needs_req: assert property (rsp_valid |-> req_valid)
        else $error("result without request");
    a_mul_low: assert property (rsp_valid && req.op == OP_MUL |-> rsp.value == prod_lo)
        else $error("low product wrong");
    a_mulw_sext: assert property (rsp_valid && req.op == OP_MULW
        |-> rsp.value == {{32{prod_w[31]}}, prod_w})
        else $error("word product wrong");
    a_zero_quot: assert property (rsp_valid && req.op inside {OP_DIV, OP_DIVU} && req.b == '0
        |-> &rsp.value)
        else $error("zero divisor quotient wrong");
    a_zero_rem: assert property (rsp_valid && req.op inside {OP_REM, OP_REMU} && req.b == '0
        |-> rsp.value == req.a)
        else $error("zero divisor remainder wrong");
    a_word_sext: assert property (rsp_valid && req.op inside {OP_DIVW, OP_DIVUW, OP_REMW, OP_REMUW}
        |-> rsp.value[63:32] == {32{rsp.value[31]}})
        else $error("word result not extended");
    a_no_flag: assert property (rsp_valid |-> !rsp.illegal)
        else $error("flag raised");
    c_mul: cover property (rsp_valid && req.op == OP_MULHU);
    c_div_zero: cover property (rsp_valid && req.op == OP_DIV && req.b == '0);
    c_word: cover property (rsp_valid && req.op == OP_REMUW);
endmodule
bind integer_mul_div_unit muldiv_sva chk (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

/* File: dv/test_integer_mul_div_unit.sv */
`timescale 1ns/1ps
module test_integer_mul_div_unit;
    import muldiv_pkg::*;
    // ------------------------------
    // bench
    // ------------------------------
    localparam logic [63:0] TOP = 64'h8000_0000_0000_0000;
    localparam logic [63:0] WA = 64'hdead_beef_ffff_fff9;
    localparam logic [63:0] WB = 64'h1234_0000_0000_0002;
    logic clk;
    logic arst_n;
    logic go;
    req_s cmd;
    logic req_valid;
    req_s req;
    logic req_ready;
    logic rsp_valid;
    rsp_s rsp;
    int errors;
    int checks_done;
    muldiv_issuer pipe (.clk(clk), .arst_n(arst_n), .go(go), .cmd(cmd), .req_ready(req_ready),
        .req_valid(req_valid), .req(req));
    integer_mul_div_unit uut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run(input op_e op, input logic [63:0] a, b, exp);
        int n;
        n = 0;
        @(posedge clk);
        cmd <= '{op, a, b};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 100);
        if (rsp_valid !== 1'b1) begin
            errors++;
            end_of_test();
        end
        chk(rsp.value, exp);
        chk({63'h0, rsp.illegal}, 64'h0);
        chk({63'h0, req_ready}, 64'h1);
    endtask
    task automatic t_mul;
        run(OP_MULH, -64'h2, TOP, 64'h1);
        run(OP_MUL, -64'h2, TOP, 64'h0);
        run(OP_MULHU, -64'h2, TOP, 64'h7fff_ffff_ffff_ffff);
        run(OP_MULHSU, -64'h2, TOP, -64'h1);
        run(OP_MULW, 64'h1_0000, 64'hffff_0000_0000_8000, 64'hffff_ffff_8000_0000);
        $display("mul test done");
    endtask
    task automatic t_div;
        run(OP_DIV, -64'h7, 64'h2, -64'h3);
        run(OP_REM, -64'h7, 64'h2, -64'h1);
        run(OP_REM, 64'h7, -64'h2, 64'h1);
        run(OP_DIVU, -64'h7, 64'h2, 64'h7fff_ffff_ffff_fffc);
        run(OP_REMU, -64'h7, 64'h2, 64'h1);
        run(OP_DIVW, WA, WB, -64'h3);
        run(OP_REMW, WA, WB, -64'h1);
        run(OP_DIVUW, 64'h5_ffff_fffe, 64'h7_0000_0001, -64'h2);
        run(OP_REMUW, 64'h8000_0001, 64'h9_8000_0002, 64'hffff_ffff_8000_0001);
        $display("div test done");
    endtask
    task automatic t_special;
        run(OP_DIV, 64'h5, 64'h0, -64'h1);
        run(OP_DIVU, 64'h5, 64'h0, -64'h1);
        run(OP_REM, -64'h5, 64'h0, -64'h5);
        run(OP_REMU, 64'h5, 64'h0, 64'h5);
        run(OP_DIVUW, 64'h5, 64'hffff_ffff_0000_0000, -64'h1);
        run(OP_REMW, 64'h8000_0000, 64'h1_0000_0000, 64'hffff_ffff_8000_0000);
        run(OP_DIV, TOP, -64'h1, TOP);
        run(OP_REM, TOP, -64'h1, 64'h0);
        run(OP_DIVW, 64'h8000_0000, 64'hffff_ffff, 64'hffff_ffff_8000_0000);
        run(OP_REMW, 64'h8000_0000, 64'hffff_ffff, 64'h0);
        $display("special test done");
    endtask
    initial begin
        arst_n = 1'b0;
        go = 1'b0;
        cmd = '0;
        errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_mul();
        t_div();
        t_special();
        end_of_test();
    end
endmodule

/* File: verilog/divider_core.sv */
`timescale 1ns/1ps
module divider_core
    import muldiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic word,
    input wire logic [XLEN-1:0] dividend,
    input wire logic [XLEN-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [XLEN-1:0] quot,
    output logic [XLEN-1:0] rem
);
    // ----------------------------------------
    // restoring unsigned divider, one bit per cycle
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_r;
    logic [XLEN-1:0] q_r;
    logic [XLEN:0] r_r;
    logic [XLEN-1:0] d_r;
    logic [XLEN:0] shifted;
    logic [XLEN:0] trial;
    logic [CNT_W-1:0] steps;

    assign steps = word ? DIV_STEPS_WORD : DIV_STEPS_FULL;
    assign shifted = {r_r[XLEN-1:0], q_r[XLEN-1]};
    assign trial = shifted - {1'b0, d_r};
    assign busy = (cnt_r != '0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            q_r <= '0;
            r_r <= '0;
            d_r <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_r <= steps;
                // the word dividend is pre-aligned to the top for a short run; the divisor is loaded as is
                q_r <= word ? {dividend[WLEN-1:0], {WLEN{1'b0}}} : dividend;
                r_r <= '0;
                d_r <= divisor;
            end else if (busy) begin
                cnt_r <= cnt_r - 1'b1;
                if (!trial[XLEN]) begin // see RQ4
                    r_r <= trial;
                    q_r <= {q_r[XLEN-2:0], 1'b1};
                end else begin
                    r_r <= shifted;
                    q_r <= {q_r[XLEN-2:0], 1'b0};
                end
                if (cnt_r == 7'h01) begin
                    done <= 1'b1;
                end
            end
        end
    end

    assign quot = q_r;
    assign rem = r_r[XLEN-1:0];
endmodule

/* File: verilog/integer_mul_div_unit.sv */
`timescale 1ns/1ps
module integer_mul_div_unit
    import muldiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output rsp_s rsp
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [XLEN-1:0] sext_word(input logic [WLEN-1:0] v);
        return {{(XLEN-WLEN){v[WLEN-1]}}, v};
    endfunction

    function automatic logic [XLEN-1:0] negate(input logic [XLEN-1:0] v, input logic en);
        return en ? (~v + 1'b1) : v;
    endfunction

    function automatic logic [XLEN-1:0] fit_width(input logic [XLEN-1:0] v, input logic w);
        return w ? sext_word(v[WLEN-1:0]) : v;
    endfunction

    function automatic logic is_div_op(input op_e op);
        return op inside {OP_DIV, OP_DIVU, OP_REM, OP_REMU,
                          OP_DIVW, OP_DIVUW, OP_REMW, OP_REMUW};
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_HOLD} state_e;
    state_e state_r;

    // ----------------------------------------
    // operand shaping
    // ----------------------------------------
    logic word_op, signed_div, rem_op, div_start, div_busy, div_done;
    logic [XLEN-1:0] a_ext, b_ext, a_mag, b_mag, dq, dr, qfix, rfix;
    logic a_neg, b_neg, by_zero, ovf;
    logic [XLEN-1:0] min_neg;

    assign word_op = req.op inside {OP_DIVW, OP_DIVUW, OP_REMW, OP_REMUW};
    assign signed_div = req.op inside {OP_DIV, OP_REM, OP_DIVW, OP_REMW};
    assign rem_op = req.op inside {OP_REM, OP_REMU, OP_REMW, OP_REMUW};
    // word forms work on the low 32 bits, extended per signedness
    assign a_ext = word_op ? (signed_div ? sext_word(req.a[WLEN-1:0])
                                         : {{(XLEN-WLEN){1'b0}}, req.a[WLEN-1:0]})
                           : req.a; // see RQ7
    assign b_ext = word_op ? (signed_div ? sext_word(req.b[WLEN-1:0])
                                         : {{(XLEN-WLEN){1'b0}}, req.b[WLEN-1:0]})
                           : req.b; // see RQ7
    assign a_neg = signed_div && a_ext[XLEN-1];
    assign b_neg = signed_div && b_ext[XLEN-1];
    assign a_mag = negate(a_ext, a_neg);
    assign b_mag = negate(b_ext, b_neg);
    assign by_zero = (b_ext == '0);
    assign min_neg = word_op ? sext_word({1'b1, {(WLEN-1){1'b0}}})
                             : {1'b1, {(XLEN-1){1'b0}}}; // see RQ12
    assign ovf = signed_div && (a_ext == min_neg) && (b_ext == '1);

    // ----------------------------------------
    // multiplier, single cycle
    // ----------------------------------------
    logic [2*XLEN-1:0] prod_ss, prod_su, prod_uu;
    logic [2*WLEN-1:0] prod_w;
    logic [XLEN-1:0] mul_res;

    assign prod_ss = $signed({{XLEN{req.a[XLEN-1]}}, req.a})
                   * $signed({{XLEN{req.b[XLEN-1]}}, req.b});
    assign prod_su = $signed({{XLEN{req.a[XLEN-1]}}, req.a})
                   * $signed({{XLEN{1'b0}}, req.b});
    assign prod_uu = req.a * req.b;
    assign prod_w = req.a[WLEN-1:0] * req.b[WLEN-1:0];

    // the unsigned product serves both halves only for MUL and MULHU; MULH and MULHSU use their own products
    always_comb begin // see RQ14
        mul_res = prod_uu[XLEN-1:0]; // see RQ1
        unique case (req.op)
            OP_MULH: mul_res = prod_ss[2*XLEN-1:XLEN]; // see RQ2
            OP_MULHSU: mul_res = prod_su[2*XLEN-1:XLEN]; // see RQ2
            OP_MULHU: mul_res = prod_uu[2*XLEN-1:XLEN]; // see RQ2
            OP_MULW: mul_res = sext_word(prod_w[WLEN-1:0]); // see RQ3
            default: mul_res = prod_uu[XLEN-1:0];
        endcase
    end

    // ----------------------------------------
    // pairing memory, divide and remainder share one run
    // ----------------------------------------
    logic pair_ok_r;
    logic pair_word_r;
    logic pair_signed_r;
    logic [XLEN-1:0] pair_a_r;
    logic [XLEN-1:0] pair_b_r;
    logic [XLEN-1:0] pair_q_r;
    logic [XLEN-1:0] pair_rem_r;
    logic pair_hit;

    // same operands, signedness and width as the last finished run
    assign pair_hit = pair_ok_r && is_div_op(req.op)
                      && (req.a == pair_a_r) && (req.b == pair_b_r)
                      && (word_op == pair_word_r) && (signed_div == pair_signed_r); // see RQ15

    // kept until the next run overwrites it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_ok_r <= 1'b0;
            pair_word_r <= 1'b0;
            pair_signed_r <= 1'b0;
            pair_a_r <= '0;
            pair_b_r <= '0;
            pair_q_r <= '0;
            pair_rem_r <= '0;
        end else if (state_r == ST_DIV && div_done) begin
            pair_ok_r <= 1'b1;
            pair_word_r <= word_op;
            pair_signed_r <= signed_div;
            pair_a_r <= req.a;
            pair_b_r <= req.b;
            pair_q_r <= fit_width(qfix, word_op); // see RQ15
            pair_rem_r <= fit_width(rfix, word_op); // see RQ15
        end
    end

    // ----------------------------------------
    // divider and result fixup
    // ----------------------------------------
    assign div_start = (state_r == ST_IDLE) && req_valid && HAS_DIV && is_div_op(req.op)
                       && !by_zero && !ovf
                       && !pair_hit && !div_busy;

    divider_core u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(div_start),
        .word(word_op),
        .dividend(a_mag),
        .divisor(b_mag),
        .busy(div_busy),
        .done(div_done),
        .quot(dq),
        .rem(dr)
    );

    assign qfix = negate(dq, a_neg ^ b_neg); // see RQ4
    assign rfix = negate(dr, a_neg); // see RQ5

    logic [XLEN-1:0] div_res, special_res;
    logic [XLEN-1:0] raw;
    always_comb begin
        raw = rem_op ? rfix : qfix; // see RQ6
        div_res = fit_width(raw, word_op); // see RQ8
        if (by_zero) begin
            // no trap or flag, only the defined values
            special_res = rem_op ? a_ext : '1; // see RQ9 see RQ10 see RQ16
        end else begin
            special_res = rem_op ? '0 : a_ext; // see RQ11
        end
        if (word_op) begin
            special_res = sext_word(special_res[WLEN-1:0]); // see RQ8 see RQ12
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        if (!is_div_op(req.op)) begin
                            rsp_valid <= 1'b1;
                            rsp <= '{value: mul_res, illegal: 1'b0};
                            state_r <= ST_HOLD;
                        end else if (!HAS_DIV) begin
                            rsp_valid <= 1'b1;
                            rsp <= '{value: '0, illegal: 1'b1}; // see RQ13
                            state_r <= ST_HOLD;
                        end else if (by_zero || ovf) begin
                            rsp_valid <= 1'b1;
                            rsp <= '{value: special_res, illegal: 1'b0};
                            state_r <= ST_HOLD;
                        end else if (pair_hit) begin
                            // fused answer from the previous run
                            rsp_valid <= 1'b1;
                            rsp <= '{value: (rem_op ? pair_rem_r : pair_q_r), illegal: 1'b0};
                            state_r <= ST_HOLD;
                        end else begin
                            state_r <= ST_DIV;
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        rsp_valid <= 1'b1;
                        rsp <= '{value: div_res, illegal: 1'b0}; // see RQ17
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // request accepted when its answer is presented
    assign req_ready = rsp_valid; // see RQ17
endmodule

/* File: verilog/muldiv_pkg.sv */
// Operation
// RQ1: low multiply returns the least significant xlen bits of the product
// RQ2: high multiplies return upper xlen bits, signed, unsigned or mixed operands
// RQ3: word multiply uses low 32 bits, result sign-extended to 64
// RQ4: divides are full width, quotient truncated toward zero
// RQ5: remainder matches the division; signed remainder takes the dividend sign
// RQ6: dividend equals divisor times quotient plus remainder, except overflow
// RQ7: word divides use low 32 bits, quotient sign-extended to 64
// RQ8: word remainders always sign-extend, divide by zero included
// RQ9: divide by zero gives an all-ones quotient of the operation width
// RQ10: remainder by zero returns the dividend unchanged
// RQ11: most negative over minus one gives dividend quotient, zero remainder
// RQ12: special-case width is xlen for full forms, 32 for word forms
// RQ13: multiply-only build keeps all multiplies and drops divide and remainder
// RQ14: high then low multiply with same sources may fuse into one multiply
// RQ15: divide then matching remainder with same sources may share one divide
// RQ16: divide by zero and overflow raise no trap or flag
// RQ17: operands held until done; one result per operation, in order
package muldiv_pkg;
    localparam int XLEN = 64;
    localparam int WLEN = 32;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] DIV_STEPS_FULL = 7'h40;
    localparam logic [CNT_W-1:0] DIV_STEPS_WORD = 7'h20;
    localparam bit HAS_DIV = 1'b1;

    typedef enum logic [3:0] {
        OP_MUL, OP_MULH, OP_MULHSU, OP_MULHU, OP_MULW,
        OP_DIV, OP_DIVU, OP_REM, OP_REMU,
        OP_DIVW, OP_DIVUW, OP_REMW, OP_REMUW
    } op_e;

    typedef struct packed {
        op_e op;
        logic [XLEN-1:0] a;
        logic [XLEN-1:0] b;
    } req_s;

    typedef struct packed {
        logic [XLEN-1:0] value;
        logic illegal;
    } rsp_s;
endpackage
